// file: apm_cfg.svh
// register map, field positions and reset values of the audio pin mux
`ifndef APM_CFG_SVH
`define APM_CFG_SVH

`define APM_NUM_PINS 7
`define APM_NUM_LANES 3
`define APM_ADDR_W 5

`define APM_OFS_CTRL 5'h00
`define APM_OFS_PEN 5'h04
`define APM_OFS_PDIR 5'h08
`define APM_OFS_PDATA 5'h0c
`define APM_OFS_PLEVEL 5'h10

`define APM_CTRL_AUDIO_BIT 0
`define APM_CTRL_TXMODE_BIT 1
`define APM_CTRL_EXTCLK_BIT 2
`define APM_CTRL_LANE_LSB 4
`define APM_CTRL_LANE_MSB 6

`define APM_CTRL_RST 7'h00
`define APM_PORT_RST 7'h00

`define APM_PIN_LANE_A 0
`define APM_PIN_LANE_B 1
`define APM_PIN_LANE_C 2
`define APM_PIN_LANE_D 3
`define APM_PIN_LANE_E 4
`define APM_PIN_TX_CLOCK 5
`define APM_PIN_TX_OUTPUT 6

`endif

// file: apm_pkg.sv
// types shared by the audio pin mux modules
package apm_pkg;

	// per-pin steering handed from the register file to a pin cell
	typedef struct packed {
		logic func_sel;
		logic func_oe;
		logic func_out;
		logic gp_en;
		logic gp_dir;
		logic gp_out;
	} apm_pin_ctl_t;

	// drive value and output enable of one pad
	typedef struct packed {
		logic pad_out;
		logic pad_oe;
	} apm_pad_drv_t;

endpackage

// file: apm_pin_cell.sv
// one pad of the audio pin mux: function/port select, sync, drive
`include "apm_cfg.svh"

module apm_pin_cell
	import apm_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire apm_pin_ctl_t ctl,
	input wire logic pad_in,
	output apm_pad_drv_t drv_q,
	output logic sampled_q
);

	logic meta_q;
	logic sync_q;
	logic sample_en;
	apm_pad_drv_t drv_d;

	// ----------------------------------------------------------
	// drive select
	// ----------------------------------------------------------
	always_comb begin
		drv_d = '0;
		sample_en = 1'b0;
		if (ctl.func_sel) begin
			drv_d.pad_oe = ctl.func_oe;
			drv_d.pad_out = ctl.func_oe & ctl.func_out;
			sample_en = ~ctl.func_oe;
		end else if (ctl.gp_en) begin
			drv_d.pad_oe = ctl.gp_dir;
			drv_d.pad_out = ctl.gp_dir & ctl.gp_out;
			sample_en = ~ctl.gp_dir;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			drv_q <= '0;
		end else begin
			drv_q <= drv_d;
		end
	end

	// ----------------------------------------------------------
	// input synchroniser
	// ----------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= pad_in;
			sync_q <= meta_q;
		end
	end

	// disconnected or driving pads are not sampled
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sampled_q <= 1'b0;
		end else begin
			sampled_q <= sync_q & sample_en;
		end
	end

endmodule // apm_pin_cell

// file: apm_audio_pin_mux.sv
// pin multiplexer for the serial audio lanes and the spdif pins
//
// Operation
// - pin out4_in1 drives transmit four or feeds receive one by lane role.
// - pin out3_in2 drives transmit three or feeds receive two by lane role.
// - pin out2_in3 drives transmit two or feeds receive three by lane role.
// - pins out1 and out0 only drive transmit one and zero, never receive.
// - in port mode each pin is set alone to input, output or disconnected.
// - after reset all pins are in port mode, disconnected, not sampled.
// - external clock is the clock pin, at 256, 384 or 512 times the rate.
// - in transmit mode the audio output pin carries the biphase stream.
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`include "apm_cfg.svh"

module apm_audio_pin_mux
	import apm_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	// avalon-mm slave
	input wire logic [`APM_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// serial audio side
	input wire logic [4:0] tx_shift_bits,
	output logic [`APM_NUM_LANES-1:0] rx_shift_bits,
	// digital audio transmitter side
	input wire logic biphase_bit,
	output logic tx_ext_clk,
	output logic tx_ext_clk_sel,
	// pads
	input wire logic audio_lane_out4_in1_in,
	output logic audio_lane_out4_in1_out,
	output logic audio_lane_out4_in1_oe,
	input wire logic audio_lane_out3_in2_in,
	output logic audio_lane_out3_in2_out,
	output logic audio_lane_out3_in2_oe,
	input wire logic audio_lane_out2_in3_in,
	output logic audio_lane_out2_in3_out,
	output logic audio_lane_out2_in3_oe,
	input wire logic audio_lane_out1_in,
	output logic audio_lane_out1_out,
	output logic audio_lane_out1_oe,
	input wire logic audio_lane_out0_in,
	output logic audio_lane_out0_out,
	output logic audio_lane_out0_oe,
	input wire logic audio_clock_input_pin_in,
	output logic audio_clock_input_pin_out,
	output logic audio_clock_input_pin_oe,
	input wire logic digital_audio_output_pin_in,
	output logic digital_audio_output_pin_out,
	output logic digital_audio_output_pin_oe
);

	localparam int NP = `APM_NUM_PINS;

	logic [6:0] ctrl_q;
	logic [NP-1:0] pen_q;
	logic [NP-1:0] pdir_q;
	logic [NP-1:0] pdata_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic tx_ext_clk_q;
	logic req;
	logic wr_go;
	logic audio_mode;
	logic tx_mode;
	logic ext_sel;
	logic [`APM_NUM_LANES-1:0] lane_rx;
	logic [NP-1:0] pad_in_v;
	logic [NP-1:0] func_sel_v;
	logic [NP-1:0] func_oe_v;
	logic [NP-1:0] func_out_v;
	logic [NP-1:0] sampled_v;
	logic [NP-1:0] pdata_rd;
	apm_pad_drv_t drv_v [NP];

	// ----------------------------------------------------------
	// avalon-mm slave
	// ----------------------------------------------------------
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign wr_go = avs_write & ack_q & avs_byteenable[0];
	assign avs_readdata = rdata_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	always_comb begin
		rdata_d = '0;
		case (avs_address)
			`APM_OFS_CTRL: rdata_d[6:0] = ctrl_q;
			`APM_OFS_PEN: rdata_d[NP-1:0] = pen_q;
			`APM_OFS_PDIR: rdata_d[NP-1:0] = pdir_q;
			`APM_OFS_PDATA: rdata_d[NP-1:0] = pdata_rd;
			`APM_OFS_PLEVEL: rdata_d[NP-1:0] = sampled_v;
			default: rdata_d = '0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdata_q <= '0;
		end else if (avs_read & ~ack_q) begin
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------
	// control register
	// ----------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_q <= `APM_CTRL_RST;
		end else if (wr_go && avs_address == `APM_OFS_CTRL) begin
			ctrl_q <= avs_writedata[6:0];
		end
	end

	assign audio_mode = ctrl_q[`APM_CTRL_AUDIO_BIT];
	assign tx_mode = ctrl_q[`APM_CTRL_TXMODE_BIT];
	assign ext_sel = ctrl_q[`APM_CTRL_EXTCLK_BIT];
	assign lane_rx = ctrl_q[`APM_CTRL_LANE_MSB:`APM_CTRL_LANE_LSB];

	// ----------------------------------------------------------
	// port registers
	// ----------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pen_q <= `APM_PORT_RST;
		end else if (wr_go && avs_address == `APM_OFS_PEN) begin
			pen_q <= avs_writedata[NP-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pdir_q <= `APM_PORT_RST;
		end else if (wr_go && avs_address == `APM_OFS_PDIR) begin
			pdir_q <= avs_writedata[NP-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pdata_q <= `APM_PORT_RST;
		end else if (wr_go && avs_address == `APM_OFS_PDATA) begin
			pdata_q <= avs_writedata[NP-1:0];
		end
	end

	// outputs read back their latch, inputs their pad level
	assign pdata_rd = pen_q & ~func_sel_v
		& ((pdir_q & pdata_q) | (~pdir_q & sampled_v));

	// ----------------------------------------------------------
	// function routing
	// ----------------------------------------------------------
	assign pad_in_v = {digital_audio_output_pin_in, audio_clock_input_pin_in,
		audio_lane_out0_in, audio_lane_out1_in, audio_lane_out2_in3_in,
		audio_lane_out3_in2_in, audio_lane_out4_in1_in};

	assign func_sel_v = {{2{tx_mode}}, {5{audio_mode}}};

	assign func_oe_v[`APM_PIN_LANE_A] = ~lane_rx[0];
	assign func_oe_v[`APM_PIN_LANE_B] = ~lane_rx[1];
	assign func_oe_v[`APM_PIN_LANE_C] = ~lane_rx[2];
	assign func_oe_v[`APM_PIN_LANE_D] = 1'b1;
	assign func_oe_v[`APM_PIN_LANE_E] = 1'b1;
	assign func_oe_v[`APM_PIN_TX_CLOCK] = 1'b0;
	assign func_oe_v[`APM_PIN_TX_OUTPUT] = 1'b1;

	assign func_out_v[`APM_PIN_LANE_A] = tx_shift_bits[4];
	assign func_out_v[`APM_PIN_LANE_B] = tx_shift_bits[3];
	assign func_out_v[`APM_PIN_LANE_C] = tx_shift_bits[2];
	assign func_out_v[`APM_PIN_LANE_D] = tx_shift_bits[1];
	assign func_out_v[`APM_PIN_LANE_E] = tx_shift_bits[0];
	assign func_out_v[`APM_PIN_TX_CLOCK] = 1'b0;
	assign func_out_v[`APM_PIN_TX_OUTPUT] = biphase_bit;

	// receive lanes see the pad only in function mode as receiver
	assign rx_shift_bits = sampled_v[`APM_PIN_LANE_C:`APM_PIN_LANE_A]
		& func_sel_v[`APM_PIN_LANE_C:`APM_PIN_LANE_A];

	// ----------------------------------------------------------
	// external transmitter clock
	// ----------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tx_ext_clk_q <= 1'b0;
		end else begin
			tx_ext_clk_q <= sampled_v[`APM_PIN_TX_CLOCK] & ext_sel & tx_mode;
		end
	end

	assign tx_ext_clk = tx_ext_clk_q;
	assign tx_ext_clk_sel = ext_sel & tx_mode;

	// ----------------------------------------------------------
	// pad cells
	// ----------------------------------------------------------
	for (genvar g = 0; g < NP; g++) begin : g_pin
		apm_pin_ctl_t ctl;
		assign ctl = {func_sel_v[g], func_oe_v[g], func_out_v[g],
			pen_q[g], pdir_q[g], pdata_q[g]};
		apm_pin_cell u_cell (
			.ref_clk(ref_clk),
			.srst(srst),
			.ctl(ctl),
			.pad_in(pad_in_v[g]),
			.drv_q(drv_v[g]),
			.sampled_q(sampled_v[g])
		);
	end

	assign audio_lane_out4_in1_out = drv_v[`APM_PIN_LANE_A].pad_out;
	assign audio_lane_out4_in1_oe = drv_v[`APM_PIN_LANE_A].pad_oe;
	assign audio_lane_out3_in2_out = drv_v[`APM_PIN_LANE_B].pad_out;
	assign audio_lane_out3_in2_oe = drv_v[`APM_PIN_LANE_B].pad_oe;
	assign audio_lane_out2_in3_out = drv_v[`APM_PIN_LANE_C].pad_out;
	assign audio_lane_out2_in3_oe = drv_v[`APM_PIN_LANE_C].pad_oe;
	assign audio_lane_out1_out = drv_v[`APM_PIN_LANE_D].pad_out;
	assign audio_lane_out1_oe = drv_v[`APM_PIN_LANE_D].pad_oe;
	assign audio_lane_out0_out = drv_v[`APM_PIN_LANE_E].pad_out;
	assign audio_lane_out0_oe = drv_v[`APM_PIN_LANE_E].pad_oe;
	assign audio_clock_input_pin_out = drv_v[`APM_PIN_TX_CLOCK].pad_out;
	assign audio_clock_input_pin_oe = drv_v[`APM_PIN_TX_CLOCK].pad_oe;
	assign digital_audio_output_pin_out = drv_v[`APM_PIN_TX_OUTPUT].pad_out;
	assign digital_audio_output_pin_oe = drv_v[`APM_PIN_TX_OUTPUT].pad_oe;

endmodule // apm_audio_pin_mux

// file: apm_audio_pin_mux_checker.sv
// port assertions of the audio pin mux
module apm_audio_pin_mux_checker
	import apm_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	input wire logic [2:0] rx_shift_bits,
	input wire logic biphase_bit,
	input wire logic tx_ext_clk,
	input wire logic tx_ext_clk_sel,
	input wire logic audio_lane_out4_in1_in,
	input wire logic audio_lane_out4_in1_oe,
	input wire logic audio_lane_out3_in2_in,
	input wire logic audio_lane_out2_in3_in,
	input wire logic audio_clock_input_pin_in,
	input wire logic audio_clock_input_pin_oe,
	input wire logic digital_audio_output_pin_oe,
	input wire logic digital_audio_output_pin_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	reset_quiet_a: assert property (
		$past(srst) |-> !audio_lane_out4_in1_oe && rx_shift_bits == 3'h0
		&& !audio_clock_input_pin_oe && !digital_audio_output_pin_oe)
		else $error("pads active after reset");
	rx_one_a: assert property (
		rx_shift_bits[0] |-> $past(audio_lane_out4_in1_in, 3))
		else $error("receive one not from its pad");
	rx_two_a: assert property (
		rx_shift_bits[1] |-> $past(audio_lane_out3_in2_in, 3))
		else $error("receive two not from its pad");
	rx_three_a: assert property (
		rx_shift_bits[2] |-> $past(audio_lane_out2_in3_in, 3))
		else $error("receive three not from its pad");
	ext_clk_src_a: assert property (
		tx_ext_clk |-> $past(audio_clock_input_pin_in, 4))
		else $error("external clock not from its pad");
	clk_pin_in_a: assert property (
		tx_ext_clk_sel && $past(tx_ext_clk_sel) |-> !audio_clock_input_pin_oe)
		else $error("clock pin driven in function mode");
	biphase_out_a: assert property (
		tx_ext_clk_sel && $past(tx_ext_clk_sel) |->
		digital_audio_output_pin_oe
		&& digital_audio_output_pin_out == $past(biphase_bit))
		else $error("output pin not carrying coded stream");
	bus_one_wait_a: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait longer than one cycle");
	bus_idle_a: assert property (
		!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait raised while idle");
	read_upper_a: assert property (
		avs_read && !avs_waitrequest |-> avs_readdata[31:7] == 25'h0)
		else $error("upper read bits set");
	cover property (rx_shift_bits == 3'h7);
	cover property (tx_ext_clk);
	cover property (avs_write && !avs_waitrequest);
endmodule // apm_audio_pin_mux_checker

// file: apm_codec_model.sv
// far-side codec and receiver model on the seven pads
module apm_codec_model
	import apm_pkg::*;
(
	input wire logic [6:0] dut_oe,
	input wire logic [6:0] dut_out,
	input wire logic [6:0] drv,
	output logic [6:0] lvl
);
	timeunit 1ns;
	timeprecision 1ps;
	// pads the mux leaves undriven carry the far side's level
	assign lvl = (dut_oe & dut_out) | (~dut_oe & drv);
endmodule // apm_codec_model

// file: test_audio_port_pin_mux.sv
// self-checking bench of the audio pin mux
`include "apm_cfg.svh"
`define CHK(g, e) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("BAD t=%0t got=%h exp=%h", $time, g, e); \
	end \
end

module test_audio_port_pin_mux
	import apm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [6:0] ctrl, pen, dir, dat;
		logic [4:0] tx;
		logic bp;
		logic [6:0] drv, oe, out;
		logic [2:0] rx;
		logic [6:0] rd;
		logic [6:0] lvl;
	} apm_row_t;
	logic ref_clk, srst, avs_read, avs_write, avs_waitrequest, biphase_bit;
	logic tx_ext_clk, tx_ext_clk_sel;
	logic [4:0] avs_address, tx_shift_bits;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	logic [2:0] rx_shift_bits;
	logic [6:0] p_oe, p_out, p_lvl, drv;
	int err_total, n_checks;
	apm_row_t rows [7];
	logic ext_exp;

	apm_codec_model u_codec (.dut_oe(p_oe), .dut_out(p_out), .drv(drv),
		.lvl(p_lvl));
	apm_audio_pin_mux u_dut (.ref_clk(ref_clk), .srst(srst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tx_shift_bits(tx_shift_bits),
		.rx_shift_bits(rx_shift_bits), .biphase_bit(biphase_bit),
		.tx_ext_clk(tx_ext_clk), .tx_ext_clk_sel(tx_ext_clk_sel),
		.audio_lane_out4_in1_in(p_lvl[0]), .audio_lane_out4_in1_out(p_out[0]),
		.audio_lane_out4_in1_oe(p_oe[0]), .audio_lane_out3_in2_in(p_lvl[1]),
		.audio_lane_out3_in2_out(p_out[1]), .audio_lane_out3_in2_oe(p_oe[1]),
		.audio_lane_out2_in3_in(p_lvl[2]), .audio_lane_out2_in3_out(p_out[2]),
		.audio_lane_out2_in3_oe(p_oe[2]), .audio_lane_out1_in(p_lvl[3]),
		.audio_lane_out1_out(p_out[3]), .audio_lane_out1_oe(p_oe[3]),
		.audio_lane_out0_in(p_lvl[4]), .audio_lane_out0_out(p_out[4]),
		.audio_lane_out0_oe(p_oe[4]), .audio_clock_input_pin_in(p_lvl[5]),
		.audio_clock_input_pin_out(p_out[5]),
		.audio_clock_input_pin_oe(p_oe[5]),
		.digital_audio_output_pin_in(p_lvl[6]),
		.digital_audio_output_pin_out(p_out[6]),
		.digital_audio_output_pin_oe(p_oe[6]));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic bus(input logic [4:0] a, input logic wr,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 20) begin
			err_total++;
			test_done();
		end
	endtask

	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial begin
		srst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		tx_shift_bits = 5'h00;
		biphase_bit = 1'b0;
		drv = 7'h00;
		err_total = 0;
		n_checks = 0;
		rows = '{
			'{7'h00,7'h7f,7'h7f,7'h55,5'h00,1'b0,7'h00,
				7'h7f,7'h55,3'h0,7'h55,7'h00},
			'{7'h00,7'h0f,7'h03,7'h7f,5'h00,1'b0,7'h7c,
				7'h03,7'h03,3'h0,7'h0f,7'h0c},
			'{7'h01,7'h00,7'h00,7'h00,5'h16,1'b0,7'h00,
				7'h1f,7'h0d,3'h0,7'h00,7'h00},
			'{7'h71,7'h00,7'h00,7'h00,5'h1f,1'b0,7'h07,
				7'h18,7'h18,3'h7,7'h00,7'h07},
			'{7'h04,7'h20,7'h00,7'h00,5'h00,1'b0,7'h20,
				7'h00,7'h00,3'h0,7'h20,7'h20},
			'{7'h06,7'h00,7'h00,7'h00,5'h00,1'b1,7'h20,
				7'h40,7'h40,3'h0,7'h00,7'h20},
			'{7'h33,7'h00,7'h00,7'h00,5'h05,1'b0,7'h21,
				7'h5c,7'h14,3'h1,7'h00,7'h21}};
		repeat (6) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		`CHK(p_oe, 7'h00)
		foreach (rows[i]) begin
			bus(`APM_OFS_CTRL, 1'b1, {25'h0, rows[i].ctrl}, rd);
			bus(`APM_OFS_PEN, 1'b1, {25'h0, rows[i].pen}, rd);
			bus(`APM_OFS_PDIR, 1'b1, {25'h0, rows[i].dir}, rd);
			bus(`APM_OFS_PDATA, 1'b1, {25'h0, rows[i].dat}, rd);
			tx_shift_bits <= rows[i].tx;
			biphase_bit <= rows[i].bp;
			drv <= rows[i].drv;
			repeat (6) @(posedge ref_clk);
			`CHK(p_oe, rows[i].oe)
			`CHK(p_out & p_oe, rows[i].out)
			`CHK(rx_shift_bits, rows[i].rx)
			ext_exp = rows[i].ctrl[`APM_CTRL_EXTCLK_BIT]
				& rows[i].ctrl[`APM_CTRL_TXMODE_BIT];
			`CHK(tx_ext_clk_sel, ext_exp)
			`CHK(tx_ext_clk, ext_exp & rows[i].drv[`APM_PIN_TX_CLOCK])
			bus(`APM_OFS_PDATA, 1'b0, 32'h0, rd);
			`CHK(rd, {25'h0, rows[i].rd})
			bus(`APM_OFS_PLEVEL, 1'b0, 32'h0, rd);
			`CHK(rd, {25'h0, rows[i].lvl})
		end
		bus(`APM_OFS_CTRL, 1'b1, 32'h0, rd);
		bus(`APM_OFS_PDATA, 1'b1, 32'h7f, rd);
		avs_byteenable <= 4'h0;
		bus(`APM_OFS_PEN, 1'b1, 32'h7f, rd);
		avs_byteenable <= 4'hf;
		bus(`APM_OFS_PEN, 1'b0, 32'h0, rd);
		`CHK(rd, 32'h0)
		bus(5'h14, 1'b0, 32'h0, rd);
		`CHK(rd, 32'h0)
		`CHK(p_oe, 7'h00)
		bus(`APM_OFS_PDIR, 1'b1, 32'h7f, rd);
		bus(`APM_OFS_PEN, 1'b1, 32'h7f, rd);
		repeat (3) @(posedge ref_clk);
		`CHK(p_oe & p_out, 7'h7f)
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		`CHK(p_oe, 7'h00)
		bus(`APM_OFS_PDATA, 1'b0, 32'h0, rd);
		`CHK(rd, 32'h0)
		test_done();
	end
endmodule // test_audio_port_pin_mux

bind apm_audio_pin_mux apm_audio_pin_mux_checker u_chk (.*);
